// ---- src/mpg_gpio.sv ----
// The register addresses and the APB slave port are this design's own decisions.
`include "mpg_map.svh"

// Overview of operation
// - Port zero pins one-six have per-bit direction.
// - Port zero pins zero, seven are input-only.
// - One bit pulls up port zero pins one-six in input.
// - Output level change on port zero raises request.
// - Reset puts every port pin into input.
// - Port one per-bit direction, one group pull-up.
// - Analog-selected port one pins never pulled up.
// - Port two per-bit direction, one group pull-up.
// - Port three per-bit direction, one group pull-up.
// - Port four direction set whole by expansion register.
// - Port four falling edge sets key flag.
// - Expansion mode: port four is address/data bus.
// - Port five per-bit direction, pull-up, upper address.
// - Port six has per-bit direction.
// - Pull-up bit six serves port six upper.
// - Port six lower pull-ups fixed, not software.
// - Expansion mode: port six upper carries bus strobes.
// - Unused wait leaves its pin general purpose.
// - Direction bit one means input, zero output.
// - Reset loads direction registers with all ones.

module mpg_gpio #(
	parameter bit         MASK_ROM   = 1'b1,
	parameter logic [3:0] MASK_P6_PU = 4'h0
) (
	// Clock and reset.
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	// APB slave.
	input  wire mpg_pkg::mpg_apb_req_type apb_req,
	output logic                       pready,
	output logic [31:0]                prdata,
	output logic                       pslverr,
	// Pads.
	input  wire logic [6:0][7:0]       pad_in,
	output mpg_pkg::mpg_pad_type       pad_q,
	// Analog converter input select on port one.
	input  wire logic [7:0]            adc_sel,
	// External memory bus controller.
	input  wire mpg_pkg::mpg_xbus_type xbus,
	output logic                       ext_wait_q,
	// External interrupt requests from port zero, one-cycle pulses.
	output logic [7:0]                 ext_irq_q,
	// Key test input flag level.
	output logic                       key_flag_q
);
	import mpg_pkg::*;

	logic [6:0][7:0] latch_q;
	logic [6:0][7:0] dir_q;
	logic [7:0]      pullup_option_low_reg_q;
	logic [7:0]      memx_q;
	logic [7:0]      p4_prev_q;
	logic [6:0][7:0] xsel;
	logic [6:0][7:0] xval;
	logic [6:0][7:0] xoe;
	logic [6:0][7:0] dir_eff;
	logic [6:0][7:0] pu_grp;
	logic [6:0][7:0] in_mode;
	mpg_pad_type     pad_d;
	logic            acc;
	logic            wr_en;
	logic            hit_latch;
	logic            hit_dir;
	logic [2:0]      idx;
	logic [31:0]     rd_d;
	logic            err_d;
	logic            key_fall;

	// Register bases as typed constants so that their upper bits can be sliced.
	localparam logic [11:0] LATCH_BASE = `MPG_LATCH_BASE;
	localparam logic [11:0] DIR_BASE   = `MPG_DIR_BASE;

	//--------------------------------------------------------------------
	// APB slave
	//--------------------------------------------------------------------

	// Access phase gets one wait cycle; write and read complete with pready.
	assign acc   = apb_req.psel & apb_req.penable;
	assign wr_en = acc & pready & apb_req.pwrite & ~pslverr;
	assign idx   = apb_req.paddr[4:2];
	assign hit_latch = (apb_req.paddr[11:5] == LATCH_BASE[11:5]) && (idx != 3'h7) &&
	                   (apb_req.paddr[1:0] == 2'b00);
	assign hit_dir   = (apb_req.paddr[11:5] == DIR_BASE[11:5]) && (idx != 3'h7) &&
	                   (idx != 3'h4) && (apb_req.paddr[1:0] == 2'b00);

	// Read mux: input-mode pins read the pad, output-mode pins the latch.
	always_comb begin
		rd_d  = 32'h0000_0000;
		err_d = 1'b0;
		if (hit_latch) begin
			rd_d[7:0] = (pad_in[idx] & in_mode[idx]) | (latch_q[idx] & ~in_mode[idx]);
		end else if (hit_dir) begin
			rd_d[7:0] = dir_q[idx];
		end else if (apb_req.paddr == `MPG_PULLUP_OPTION_LOW_REG_ADDR) begin
			rd_d[7:0] = pullup_option_low_reg_q;
		end else if (apb_req.paddr == `MPG_MEMX_ADDR) begin
			rd_d[7:0] = memx_q;
		end else if (apb_req.paddr == `MPG_KEYR_ADDR) begin
			rd_d[`MPG_KEYR_FLAG_BIT] = key_flag_q;
		end else begin
			err_d = 1'b1;
		end
	end

	// Handshake and read data registers.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= acc & ~pready;
			prdata  <= (acc & ~pready & ~apb_req.pwrite) ? rd_d : 32'h0000_0000;
			pslverr <= acc & ~pready & err_d;
		end
	end

	//--------------------------------------------------------------------
	// Control registers
	//--------------------------------------------------------------------

	// Output latches.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			latch_q <= {7{`MPG_LATCH_RST}};
		end else if (wr_en && hit_latch) begin
			latch_q[idx] <= apb_req.pwdata[7:0];
		end
	end

	// Direction registers; one selects input.
	// all ones
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dir_q <= {7{`MPG_DIR_RST}};
		end else if (wr_en && hit_dir) begin
			dir_q[idx] <= (idx == 3'h0) ? (apb_req.pwdata[7:0] | ~`MPG_P0_IO_MASK)
			                            : apb_req.pwdata[7:0];
		end
	end

	// Pull-up option and memory expansion control.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pullup_option_low_reg_q <= `MPG_PULLUP_OPTION_LOW_REG_RST;
			memx_q <= `MPG_MEMX_RST;
		end else if (wr_en) begin
			if (apb_req.paddr == `MPG_PULLUP_OPTION_LOW_REG_ADDR) begin
				pullup_option_low_reg_q <= apb_req.pwdata[7:0];
			end
			if (apb_req.paddr == `MPG_MEMX_ADDR) begin
				memx_q <= {5'h00, apb_req.pwdata[2:0]};
			end
		end
	end

	//--------------------------------------------------------------------
	// Key test input flag
	//--------------------------------------------------------------------

	assign key_fall = |(p4_prev_q & ~pad_in[4]);

	// A falling edge wins over a software clear in the same cycle.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			p4_prev_q  <= 8'hFF;
			key_flag_q <= 1'b0;
		end else begin
			p4_prev_q <= pad_in[4];
			if (key_fall) begin
				key_flag_q <= 1'b1;
			end else if (wr_en && apb_req.paddr == `MPG_KEYR_ADDR) begin
				key_flag_q <= apb_req.pwdata[`MPG_KEYR_FLAG_BIT];
			end
		end
	end

	//--------------------------------------------------------------------
	// Alternate functions and pull-up groups
	//--------------------------------------------------------------------

	// External bus takes over ports four, five and port six pins four, five, seven, plus six when wait is used.
	always_comb begin
		xsel    = '0;
		xval    = '0;
		xoe     = '0;
		dir_eff = dir_q;
		dir_eff[4] = {8{memx_q[`MPG_MEMX_P4IN_BIT]}};
		if (memx_q[`MPG_MEMX_EXT_BIT]) begin
			xsel[4] = 8'hFF;
			xval[4] = xbus.ad_out;
			xoe[4]  = {8{xbus.ad_oe}};
			xsel[5] = 8'hFF;
			xval[5] = xbus.addr_hi;
			xoe[5]  = 8'hFF;
			xsel[6] = memx_q[`MPG_MEMX_WAIT_BIT] ? `MPG_P6_BUS_ALL : `MPG_P6_BUS_NOWAIT;
			xval[6] = {xbus.astb, 1'b0, xbus.wr_n, xbus.rd_n, 4'h0};
			xoe[6]  = `MPG_P6_BUS_OUT;
		end
	end

	// Group enables per pin before the input-mode gate.
	always_comb begin
		pu_grp[0] = {8{pullup_option_low_reg_q[0]}} & `MPG_P0_IO_MASK;
		pu_grp[1] = {8{pullup_option_low_reg_q[1]}} & ~adc_sel;
		pu_grp[2] = {8{pullup_option_low_reg_q[2]}};
		pu_grp[3] = {8{pullup_option_low_reg_q[3]}};
		pu_grp[4] = {8{pullup_option_low_reg_q[4]}};
		pu_grp[5] = {8{pullup_option_low_reg_q[5]}};
		pu_grp[6] = {{4{pullup_option_low_reg_q[`MPG_PORT_SIX_UPPER_PULLUP_BIT_BIT] & MASK_ROM}}, MASK_ROM ? MASK_P6_PU : 4'h0};
	end

	// Per-port pad drive.
	for (genvar p = 0; p < 7; p++) begin : g_port
		assign in_mode[p]   = (xsel[p] & ~xoe[p]) | (~xsel[p] & dir_eff[p]);
		assign pad_d.out[p] = (xsel[p] & xval[p]) | (~xsel[p] & latch_q[p]);
		assign pad_d.oe[p]  = ~in_mode[p];
		assign pad_d.pu[p]  = pu_grp[p] & in_mode[p];
	end

	//--------------------------------------------------------------------
	// Registered pad outputs and port zero requests
	//--------------------------------------------------------------------

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pad_q      <= '0;
			ext_wait_q <= 1'b1;
		end else begin
			pad_q      <= pad_d;
			ext_wait_q <= pad_in[6][6] | ~memx_q[`MPG_MEMX_EXT_BIT] |
			              ~memx_q[`MPG_MEMX_WAIT_BIT];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ext_irq_q <= 8'h00;
		end else begin
			ext_irq_q <= pad_q.oe[0] & pad_d.oe[0] & (pad_q.out[0] ^ pad_d.out[0]);
		end
	end

	//--------------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------------

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_p0_inonly;
		!(pad_q.oe[0][0] | pad_q.oe[0][7]);
	endproperty
	a_p0_inonly: assert property (p_p0_inonly) else $error("Input-only pin driven.");

	property p_p1_dir;
		##1 pad_q.oe[1] == ~$past(dir_q[1]);
	endproperty
	a_p1_dir: assert property (p_p1_dir) else $error("Port one drive mismatch.");

	property p_p0_pu;
		##1 pad_q.pu[0] == ($past({8{pullup_option_low_reg_q[0]}} & dir_q[0]) & `MPG_P0_IO_MASK);
	endproperty
	a_p0_pu: assert property (p_p0_pu) else $error("Port zero pull-up wrong.");

	property p_adc_pu;
		adc_sel[3] |=> !pad_q.pu[1][3];
	endproperty
	a_adc_pu: assert property (p_adc_pu) else $error("Analog pin pulled up.");

	property p_no_pu_out;
		!(|(pad_q.pu & pad_q.oe));
	endproperty
	a_no_pu_out: assert property (p_no_pu_out) else $error("Pull-up on driven pin.");

	property p_key;
		(pad_in[4] != 8'hFF) && ($past(pad_in[4]) == 8'hFF) |=> key_flag_q;
	endproperty
	a_key: assert property (p_key) else $error("Falling edge missed.");

	property p_p4_whole;
		!memx_q[`MPG_MEMX_EXT_BIT] |=> pad_q.oe[4] == {8{!$past(memx_q[`MPG_MEMX_P4IN_BIT])}};
	endproperty
	a_p4_whole: assert property (p_p4_whole) else $error("Port four direction split.");

	property p_ad_bus;
		memx_q[`MPG_MEMX_EXT_BIT] |=> pad_q.out[4] == $past(xbus.ad_out);
	endproperty
	a_ad_bus: assert property (p_ad_bus) else $error("Address data not on port four.");

	property p_hi_addr;
		memx_q[`MPG_MEMX_EXT_BIT] |=> pad_q.oe[5] == 8'hFF && pad_q.out[5] == $past(xbus.addr_hi);
	endproperty
	a_hi_addr: assert property (p_hi_addr) else $error("Upper address missing.");

	property p_strobes;
		memx_q[`MPG_MEMX_EXT_BIT] |=> pad_q.out[6][4] == $past(xbus.rd_n) && pad_q.oe[6][7];
	endproperty
	a_strobes: assert property (p_strobes) else $error("Bus strobes missing.");

	property p_wait_gpio;
		memx_q[`MPG_MEMX_EXT_BIT] && !memx_q[`MPG_MEMX_WAIT_BIT] |=>
			pad_q.oe[6][6] == !$past(dir_q[6][6]);
	endproperty
	a_wait_gpio: assert property (p_wait_gpio) else $error("Wait pin not general.");

	property p_irq;
		pad_q.oe[0][2] && pad_d.oe[0][2] && (pad_q.out[0][2] != pad_d.out[0][2]) |=> ext_irq_q[2];
	endproperty
	a_irq: assert property (p_irq) else $error("Output change gave no request.");

	property p_p0_dir;
		rst_n |=> pad_q.oe[0] == ~$past(dir_q[0]);
	endproperty
	a_p0_dir: assert property (p_p0_dir) else $error("Port zero drive mismatch.");

	property p_rst_in;
		$rose(rst_n) |-> pad_q.oe == '0 && dir_q == {7{`MPG_DIR_RST}};
	endproperty
	a_rst_in: assert property (p_rst_in) else $error("Pins not input after reset.");

	property p_p1_pu;
		rst_n |=> pad_q.pu[1] == $past({8{pullup_option_low_reg_q[1]}} & dir_q[1] & ~adc_sel);
	endproperty
	a_p1_pu: assert property (p_p1_pu) else $error("Port one pull-up wrong.");

	property p_p2_pu;
		rst_n |=> pad_q.pu[2] == $past({8{pullup_option_low_reg_q[2]}} & dir_q[2]);
	endproperty
	a_p2_pu: assert property (p_p2_pu) else $error("Port two pull-up wrong.");

	property p_p3_pu;
		rst_n |=> pad_q.pu[3] == $past({8{pullup_option_low_reg_q[3]}} & dir_q[3]);
	endproperty
	a_p3_pu: assert property (p_p3_pu) else $error("Port three pull-up wrong.");

	property p_p6_dir;
		rst_n && !memx_q[`MPG_MEMX_EXT_BIT] |=> pad_q.oe[6] == ~$past(dir_q[6]);
	endproperty
	a_p6_dir: assert property (p_p6_dir) else $error("Port six drive mismatch.");

	property p_p6_upper_pu;
		rst_n && !memx_q[`MPG_MEMX_EXT_BIT] |=>
			pad_q.pu[6][7:4] == $past({4{pullup_option_low_reg_q[`MPG_PORT_SIX_UPPER_PULLUP_BIT_BIT] & MASK_ROM}} & dir_q[6][7:4]);
	endproperty
	a_p6_upper_pu: assert property (p_p6_upper_pu) else $error("Port six upper pull-up wrong.");

	property p_p6_lower_pu;
		rst_n |=> pad_q.pu[6][3:0] == ($past(dir_q[6][3:0]) & (MASK_ROM ? MASK_P6_PU : 4'h0));
	endproperty
	a_p6_lower_pu: assert property (p_p6_lower_pu) else $error("Port six lower pull-up wrong.");

	c_key:  cover property (key_fall ##1 key_flag_q);
	c_ext:  cover property (memx_q[`MPG_MEMX_EXT_BIT] && xbus.ad_oe);
	c_irq:  cover property (|ext_irq_q);
	c_wr:   cover property (wr_en && hit_dir);
	c_wait: cover property (memx_q[`MPG_MEMX_WAIT_BIT] && memx_q[`MPG_MEMX_EXT_BIT] &&
	                        !ext_wait_q);

endmodule

// ---- src/mpg_map.svh ----
`ifndef MPG_MAP_SVH
`define MPG_MAP_SVH

// Byte addresses of the output latches (port n at base + 4*n).
`define MPG_LATCH_BASE     12'h000
// Byte addresses of the direction registers (port n at base + 4*n).
`define MPG_DIR_BASE       12'h020
`define MPG_PULLUP_OPTION_LOW_REG_ADDR      12'h040
`define MPG_MEMX_ADDR      12'h044
`define MPG_KEYR_ADDR      12'h048

// Reset values.
`define MPG_DIR_RST        8'hFF
`define MPG_LATCH_RST      8'h00
`define MPG_PULLUP_OPTION_LOW_REG_RST       8'h00
`define MPG_MEMX_RST       8'h02
`define MPG_KEYR_RST       8'h00

// Field positions of the memory expansion control register.
`define MPG_MEMX_EXT_BIT   0
`define MPG_MEMX_P4IN_BIT  1
`define MPG_MEMX_WAIT_BIT  2
// Field position of the key return control register.
`define MPG_KEYR_FLAG_BIT  0
// Pull-up option bit that serves the upper half of port six.
`define MPG_PORT_SIX_UPPER_PULLUP_BIT_BIT       6

// Port zero pins one to six form the pull-up group; pins zero and seven are inputs.
`define MPG_P0_IO_MASK     8'h7E
// Port six upper pins: read, write, wait, address strobe.
`define MPG_P6_BUS_ALL     8'hF0
`define MPG_P6_BUS_NOWAIT  8'hB0
`define MPG_P6_BUS_OUT     8'hB0

`endif

// ---- src/mpg_pkg.sv ----
package mpg_pkg;

	// Pad side of all seven ports.
	typedef struct packed {
		logic [6:0][7:0] out;
		logic [6:0][7:0] oe;
		logic [6:0][7:0] pu;
	} mpg_pad_type;

	// External memory bus signals presented by the bus controller.
	typedef struct packed {
		logic [7:0] ad_out;
		logic       ad_oe;
		logic [7:0] addr_hi;
		logic       rd_n;
		logic       wr_n;
		logic       astb;
	} mpg_xbus_type;

	// APB request from the master.
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} mpg_apb_req_type;

endpackage

// ---- bench/mpg_pads_model.sv ----
// -----------------------------------------------------------------
// Pads and outside world
// -----------------------------------------------------------------
module mpg_pads_model (
	// Pad side of the design.
	input  wire mpg_pkg::mpg_pad_type pad_q,
	// Levels the outside world presents to undriven pins.
	input  wire logic [6:0][7:0]      ext_lvl,
	// Resolved pin levels.
	output logic [6:0][7:0]           pad_in
);
	timeunit 1ns;
	timeprecision 1ps;
	import mpg_pkg::*;

	// A driving pin wins, then a pull-up, then the outside level.
	always_comb begin
		for (int n = 0; n < 7; n++) begin
			for (int b = 0; b < 8; b++) begin
				pad_in[n][b] = pad_q.oe[n][b] ? pad_q.out[n][b] :
					(pad_q.pu[n][b] ? 1'b1 : ext_lvl[n][b]);
			end
		end
	end
endmodule

// ---- bench/mpg_gpio_tb.sv ----
`include "mpg_map.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
	$display("unexpected at %0t: got %h want %h", $time, g, e); end end

module mpg_gpio_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import mpg_pkg::*;

	logic                 clk_sys = 1'b0;
	logic                 rst_n   = 1'b0;
	mpg_apb_req_type      req     = '0;
	logic                 pready;
	logic [31:0]          prdata;
	logic                 pslverr;
	logic [6:0][7:0]      pad_in;
	mpg_pad_type          pad_q;
	logic [7:0]           adc_sel = 8'h00;
	mpg_xbus_type         xbus    = '0;
	logic                 ext_wait_q;
	logic [7:0]           ext_irq_q;
	logic                 key_flag_q;
	logic [6:0][7:0]      ext_lvl = '1;
	logic [7:0]           irq_seen;
	int                   num_errors = 0;
	int                   checks_done = 0;
	int                   cycles = 0;

	// Clock at 200 MHz.
	always #2.5 clk_sys = ~clk_sys;

	// Cuts a hung run short.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			report_and_stop();
		end
	end

	mpg_gpio dut (
		.clk_sys    (clk_sys),
		.rst_n      (rst_n),
		.apb_req    (req),
		.pready     (pready),
		.prdata     (prdata),
		.pslverr    (pslverr),
		.pad_in     (pad_in),
		.pad_q      (pad_q),
		.adc_sel    (adc_sel),
		.xbus       (xbus),
		.ext_wait_q (ext_wait_q),
		.ext_irq_q  (ext_irq_q),
		.key_flag_q (key_flag_q)
	);

	mpg_pads_model pads (
		.pad_q   (pad_q),
		.ext_lvl (ext_lvl),
		.pad_in  (pad_in)
	);

	// One APB transfer, held until pready is sampled high.
	task automatic apb(input bit w, input logic [11:0] a, input logic [7:0] d,
			output logic [31:0] r, output logic e);
		@(posedge clk_sys);
		req <= '{1'b1, 1'b0, w, a, {24'h0000_00, d}};
		@(posedge clk_sys);
		req.penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		r = prdata;
		e = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		`CHK(e, 1'b0)
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 8'h00, r, e);
		`CHK(r, {24'h0000_00, x})
	endtask

	// Lets a register change reach the pads.
	task automatic settle();
		repeat (3) @(posedge clk_sys);
		#1;
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Main sequence of tests.
	initial begin
		logic [31:0] r;
		logic e;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		settle();
		`CHK(pad_q.oe, '0)
		for (int n = 0; n < 7; n++) if (n != 4) rd(`MPG_DIR_BASE + 12'(4 * n), 8'hFF);
		rd(`MPG_MEMX_ADDR, `MPG_MEMX_RST);
		apb(1'b1, `MPG_DIR_BASE + 12'h010, 8'h00, r, e);
		`CHK(e, 1'b1)
		$display("test reset done");
		// Per-bit direction of ports one, two, three, five and six.
		for (int n = 1; n < 7; n++) begin
			if (n == 4) continue;
			wr(`MPG_DIR_BASE + 12'(4 * n), 8'hA5);
			settle();
			`CHK(pad_q.oe[n], 8'h5A)
			`CHK(pad_q.oe[4], 8'h00)
			// software duty: port n pins back to input.
			wr(`MPG_DIR_BASE + 12'(4 * n), 8'hFF);
		end
		$display("test direction done");
		wr(`MPG_LATCH_BASE, 8'hFF);
		wr(`MPG_DIR_BASE, 8'h00);
		settle();
		`CHK(pad_q.oe[0], `MPG_P0_IO_MASK)
		`CHK(pad_q.out[0], 8'hFF)
		rd(`MPG_DIR_BASE, 8'h81);
		wr(`MPG_LATCH_BASE, 8'h00);
		irq_seen = 8'h00;
		repeat (8) begin
			@(posedge clk_sys);
			#1;
			irq_seen |= ext_irq_q;
		end
		`CHK(irq_seen, `MPG_P0_IO_MASK)
		rd(`MPG_LATCH_BASE, 8'h81);
		$display("test port zero done");
		wr(`MPG_PULLUP_OPTION_LOW_REG_ADDR, 8'hFF);
		wr(`MPG_DIR_BASE, 8'hF0);
		adc_sel <= 8'h0F;
		settle();
		`CHK(pad_q.pu[0], 8'h70)
		`CHK(pad_q.pu[1], 8'hF0)
		`CHK(pad_q.pu[2], 8'hFF)
		`CHK(pad_q.pu[3], 8'hFF)
		`CHK(pad_q.pu[5], 8'hFF)
		`CHK(pad_q.pu[6], 8'hF0)
		`CHK(pad_q.pu[4], 8'hFF)
		wr(`MPG_DIR_BASE + 12'h014, 8'h0F);
		settle();
		`CHK(pad_q.pu[5], 8'h0F)
		wr(`MPG_PULLUP_OPTION_LOW_REG_ADDR, 8'h00);
		adc_sel <= 8'h00;
		$display("test pull-up done");
		ext_lvl[4] <= 8'hF7;
		settle();
		`CHK(key_flag_q, 1'b1)
		rd(`MPG_KEYR_ADDR, 8'h01);
		wr(`MPG_KEYR_ADDR, 8'h00);
		settle();
		`CHK(key_flag_q, 1'b0)
		wr(`MPG_LATCH_BASE + 12'h010, 8'h3C);
		wr(`MPG_MEMX_ADDR, 8'h00);
		settle();
		`CHK(pad_q.oe[4], 8'hFF)
		`CHK(pad_q.out[4], 8'h3C)
		$display("test port four done");
		xbus <= '{8'hA5, 1'b1, 8'h3C, 1'b1, 1'b0, 1'b1};
		ext_lvl[6] <= 8'hBF;
		wr(`MPG_MEMX_ADDR, 8'h01);
		settle();
		`CHK(pad_q.out[4], 8'hA5)
		`CHK(pad_q.out[5], 8'h3C)
		`CHK(pad_q.oe[6] & `MPG_P6_BUS_ALL, `MPG_P6_BUS_OUT)
		`CHK(pad_q.out[6][5:4], 2'b01)
		`CHK(ext_wait_q, 1'b1)
		wr(`MPG_DIR_BASE + 12'h018, 8'hBF);
		settle();
		`CHK(pad_q.oe[6][6], 1'b1)
		wr(`MPG_MEMX_ADDR, 8'h05);
		settle();
		`CHK(pad_q.oe[6][6], 1'b0)
		`CHK(ext_wait_q, 1'b0)
		$display("test expansion done");
		report_and_stop();
	end
endmodule
